/* dcpm_core_if.sv */
// Bundle of one core's per-pad port controls for one port
`timescale 1ns/1ps
`default_nettype none
interface dcpm_core_if #(parameter int W = 16);
  logic [W-1:0] port_out_ctrl;        // Output latch value
  logic [W-1:0] drive_enable_ctrl;    // Pad is an output when set
  logic [W-1:0] analog_select_ctrl;   // Analog function selected
  logic [W-1:0] pullup_enable_ctrl;   // Weak pull-up enable
  logic [W-1:0] pulldown_enable_ctrl; // Weak pull-down enable
  logic [W-1:0] open_drain_ctrl;      // Open-drain output mode
  logic [W-1:0] slew_ctrl;            // Slew rate selection
  logic [W-1:0] change_enable_ctrl;   // Change detection enable

  // Core side fills the bundle
  modport src (
    output port_out_ctrl, drive_enable_ctrl, analog_select_ctrl,
    output pullup_enable_ctrl, pulldown_enable_ctrl, open_drain_ctrl,
    output slew_ctrl, change_enable_ctrl
  );
  // Pad slice reads it
  modport sink (
    input port_out_ctrl, drive_enable_ctrl, analog_select_ctrl,
    input pullup_enable_ctrl, pulldown_enable_ctrl, open_drain_ctrl,
    input slew_ctrl, change_enable_ctrl
  );
endinterface
`default_nettype wire

/* dcpm_pad_slice.sv */
// One port's worth of pad output selection and input sampling
`timescale 1ns/1ps
`default_nettype none
module dcpm_pad_slice
  import dcpm_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_owner,
  dcpm_core_if.sink pri,
  dcpm_core_if.sink sec,
  input wire logic [W-1:0] i_pad_in,
  output logic [W-1:0] o_pad_out,
  output logic [W-1:0] o_pad_oe_n,
  output logic [W-1:0] o_analog,
  output logic [W-1:0] o_pullup,
  output logic [W-1:0] o_pulldown,
  output logic [W-1:0] o_open_drain,
  output logic [W-1:0] o_slew,
  output logic [W-1:0] o_pri_in,
  output logic [W-1:0] o_sec_in,
  output logic [W-1:0] o_pri_chg,
  output logic [W-1:0] o_sec_chg
);

  // Per-bit owner selection of every output-side control
  wire [W-1:0] sel_out = (i_owner & pri.port_out_ctrl)
                       | (~i_owner & sec.port_out_ctrl);
  wire [W-1:0] sel_drv = (i_owner & pri.drive_enable_ctrl)
                       | (~i_owner & sec.drive_enable_ctrl);
  wire [W-1:0] sel_ana = (i_owner & pri.analog_select_ctrl)
                       | (~i_owner & sec.analog_select_ctrl);
  wire [W-1:0] sel_pu = (i_owner & pri.pullup_enable_ctrl)
                      | (~i_owner & sec.pullup_enable_ctrl);
  wire [W-1:0] sel_pd = (i_owner & pri.pulldown_enable_ctrl)
                      | (~i_owner & sec.pulldown_enable_ctrl);
  wire [W-1:0] sel_od = (i_owner & pri.open_drain_ctrl)
                      | (~i_owner & sec.open_drain_ctrl);
  wire [W-1:0] sel_slew = (i_owner & pri.slew_ctrl)
                        | (~i_owner & sec.slew_ctrl);

  // Analog pads never drive; open drain only drives a low
  wire [W-1:0] next_oe_n = ~(sel_drv & ~sel_ana
                           & ~(sel_od & sel_out));
  wire [W-1:0] next_pad_out = sel_out & ~sel_od;

  logic [W-1:0] pad_q; // Previous pad sample for change detection
  logic primed; // Blocks a false change on the first sample

  // Input path ignores ownership entirely
  wire [W-1:0] pad_edge = i_pad_in ^ pad_q;

  // Registered pad controls
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad_out <= {W{PAD_CTRL_RST}};
      o_pad_oe_n <= {W{PAD_OE_N_RST}};
      o_analog <= {W{PAD_CTRL_RST}};
      o_pullup <= {W{PAD_CTRL_RST}};
      o_pulldown <= {W{PAD_CTRL_RST}};
      o_open_drain <= {W{PAD_CTRL_RST}};
      o_slew <= {W{PAD_CTRL_RST}};
    end else begin
      o_pad_out <= next_pad_out;
      o_pad_oe_n <= next_oe_n;
      o_analog <= sel_ana;
      o_pullup <= sel_pu;
      o_pulldown <= sel_pd;
      o_open_drain <= sel_od;
      o_slew <= sel_slew;
    end
  end

  // Both cores see every pad; each sees change events only on the pads it enabled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pad_q <= {W{IN_RST}};
      primed <= 1'h0;
      o_pri_in <= {W{IN_RST}};
      o_sec_in <= {W{IN_RST}};
      o_pri_chg <= {W{IN_RST}};
      o_sec_chg <= {W{IN_RST}};
    end else begin
      pad_q <= i_pad_in;
      primed <= 1'h1;
      o_pri_in <= i_pad_in;
      o_sec_in <= i_pad_in;
      o_pri_chg <= primed ? (pad_edge & pri.change_enable_ctrl)
                          : {W{IN_RST}};
      o_sec_chg <= primed ? (pad_edge & sec.change_enable_ctrl)
                          : {W{IN_RST}};
    end
  end

endmodule
`default_nettype wire

/* dcpm_pkg.sv */
// Shared constants for the dual-core pad ownership multiplexer
package dcpm_pkg;

  // Pad population: one narrow port followed by four wide ports
  localparam int PORT_CNT = 5;
  localparam int FIRST_W = 5;
  localparam int WIDE_W = 16;
  localparam int PIN_CNT = FIRST_W + 4 * WIDE_W;

  // Width and first pad index of each port, narrow port first
  localparam int PORT_W [PORT_CNT] = '{FIRST_W, WIDE_W, WIDE_W, WIDE_W,
                                       WIDE_W};
  localparam int PORT_BASE [PORT_CNT] = '{0, FIRST_W,
                                          FIRST_W + WIDE_W,
                                          FIRST_W + 2 * WIDE_W,
                                          FIRST_W + 3 * WIDE_W};

  // Ownership encoding: a set bit gives the pad to the primary core
  localparam logic OWN_PRIMARY = 1'h1;
  // Erased storage reads as all ones, so every pad goes to the primary
  localparam logic [PIN_CNT-1:0] OWN_ERASED = {PIN_CNT{OWN_PRIMARY}};

  // Reset values of the pad-side controls
  localparam logic PAD_OE_N_RST = 1'h1;
  localparam logic PAD_CTRL_RST = 1'h0;
  localparam logic IN_RST = 1'h0;

  // Ownership capture sequence
  typedef enum logic [0:0] {
    CAP_WAIT = 1'h0,
    CAP_HELD = 1'h1
  } dcpm_cap_t;

endpackage

/* dcpm_top.sv */
// Pad ownership multiplexer shared by the primary and secondary cores
`timescale 1ns/1ps
`default_nettype none
module dcpm_top
  import dcpm_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic [PIN_CNT-1:0] I_OWNER_CFG,
  input wire logic [PIN_CNT-1:0] I_PAD_IN,
  input wire logic [PIN_CNT-1:0] I_PRI_PORT_OUT,
  input wire logic [PIN_CNT-1:0] I_PRI_DRIVE_ENABLE,
  input wire logic [PIN_CNT-1:0] I_PRI_ANALOG_SELECT_CTRL,
  input wire logic [PIN_CNT-1:0] I_PRI_PULLUP_ENABLE_CTRL,
  input wire logic [PIN_CNT-1:0] I_PRI_PULLDOWN_ENABLE_CTRL,
  input wire logic [PIN_CNT-1:0] I_PRI_OPEN_DRAIN_CTRL,
  input wire logic [PIN_CNT-1:0] I_PRI_SLEW_CTRL,
  input wire logic [PIN_CNT-1:0] I_PRI_CHANGE_ENABLE,
  input wire logic [PIN_CNT-1:0] I_SEC_PORT_OUT,
  input wire logic [PIN_CNT-1:0] I_SEC_DRIVE_ENABLE,
  input wire logic [PIN_CNT-1:0] I_SEC_ANALOG_SELECT_CTRL,
  input wire logic [PIN_CNT-1:0] I_SEC_PULLUP_ENABLE_CTRL,
  input wire logic [PIN_CNT-1:0] I_SEC_PULLDOWN_ENABLE_CTRL,
  input wire logic [PIN_CNT-1:0] I_SEC_OPEN_DRAIN_CTRL,
  input wire logic [PIN_CNT-1:0] I_SEC_SLEW_CTRL,
  input wire logic [PIN_CNT-1:0] I_SEC_CHANGE_ENABLE,
  output logic [PIN_CNT-1:0] O_PAD_OUT,
  output logic [PIN_CNT-1:0] O_PAD_OE_N,
  output logic [PIN_CNT-1:0] O_PAD_ANALOG,
  output logic [PIN_CNT-1:0] O_PAD_PULLUP,
  output logic [PIN_CNT-1:0] O_PAD_PULLDOWN,
  output logic [PIN_CNT-1:0] O_PAD_OPEN_DRAIN,
  output logic [PIN_CNT-1:0] O_PAD_SLEW,
  output logic [PIN_CNT-1:0] O_PRI_PAD_IN,
  output logic [PIN_CNT-1:0] O_SEC_PAD_IN,
  output logic [PIN_CNT-1:0] O_PRI_CHANGE,
  output logic [PIN_CNT-1:0] O_SEC_CHANGE,
  output logic [PIN_CNT-1:0] O_OWNER_MAP,
  output logic O_MAP_VALID
);

  dcpm_cap_t state; // Capture sequence position
  dcpm_cap_t next_state; // Capture sequence next position
  logic [PIN_CNT-1:0] owner; // Live ownership map
  logic [PIN_CNT-1:0] next_owner; // Map value for the next edge

  // Capture decode: load once, then hold for good
  assign next_state = CAP_HELD;
  assign next_owner = (state == CAP_WAIT) ? I_OWNER_CFG : owner;

  // Ownership map register. Reset value is the erased map, so pads
  // stay with the primary core until the stored bits are loaded.
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= CAP_WAIT;
      owner <= OWN_ERASED;
    end else begin
      state <= next_state;
      owner <= next_owner;
    end
  end

  // Reported map and its valid flag, registered for clean outputs
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_OWNER_MAP <= OWN_ERASED;
      O_MAP_VALID <= 1'h0;
    end else begin
      O_OWNER_MAP <= next_owner;
      O_MAP_VALID <= 1'h1;
    end
  end

  // One slice per port; the slice holds all pad flip-flops
  for (genvar g = 0; g < PORT_CNT; g++) begin : g_port
    localparam int W = PORT_W[g]; // Width of this port
    localparam int B = PORT_BASE[g]; // First pad of this port

    dcpm_core_if #(.W(W)) pri_c (); // Primary controls
    dcpm_core_if #(.W(W)) sec_c (); // Secondary controls

    // Primary core bundle
    assign pri_c.port_out_ctrl = I_PRI_PORT_OUT[B +: W];
    assign pri_c.drive_enable_ctrl = I_PRI_DRIVE_ENABLE[B +: W];
    assign pri_c.analog_select_ctrl = I_PRI_ANALOG_SELECT_CTRL[B +: W];
    assign pri_c.pullup_enable_ctrl = I_PRI_PULLUP_ENABLE_CTRL[B +: W];
    assign pri_c.pulldown_enable_ctrl =
      I_PRI_PULLDOWN_ENABLE_CTRL[B +: W];
    assign pri_c.open_drain_ctrl = I_PRI_OPEN_DRAIN_CTRL[B +: W];
    assign pri_c.slew_ctrl = I_PRI_SLEW_CTRL[B +: W];
    assign pri_c.change_enable_ctrl = I_PRI_CHANGE_ENABLE[B +: W];

    // Secondary core bundle
    assign sec_c.port_out_ctrl = I_SEC_PORT_OUT[B +: W];
    assign sec_c.drive_enable_ctrl = I_SEC_DRIVE_ENABLE[B +: W];
    assign sec_c.analog_select_ctrl = I_SEC_ANALOG_SELECT_CTRL[B +: W];
    assign sec_c.pullup_enable_ctrl = I_SEC_PULLUP_ENABLE_CTRL[B +: W];
    assign sec_c.pulldown_enable_ctrl =
      I_SEC_PULLDOWN_ENABLE_CTRL[B +: W];
    assign sec_c.open_drain_ctrl = I_SEC_OPEN_DRAIN_CTRL[B +: W];
    assign sec_c.slew_ctrl = I_SEC_SLEW_CTRL[B +: W];
    assign sec_c.change_enable_ctrl = I_SEC_CHANGE_ENABLE[B +: W];

    // Port slice: narrow port first, then the four wide ports
    dcpm_pad_slice #(.W(W)) u_slice (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RESET_N),
      .i_owner(owner[B +: W]),
      .pri(pri_c),
      .sec(sec_c),
      .i_pad_in(I_PAD_IN[B +: W]),
      .o_pad_out(O_PAD_OUT[B +: W]),
      .o_pad_oe_n(O_PAD_OE_N[B +: W]),
      .o_analog(O_PAD_ANALOG[B +: W]),
      .o_pullup(O_PAD_PULLUP[B +: W]),
      .o_pulldown(O_PAD_PULLDOWN[B +: W]),
      .o_open_drain(O_PAD_OPEN_DRAIN[B +: W]),
      .o_slew(O_PAD_SLEW[B +: W]),
      .o_pri_in(O_PRI_PAD_IN[B +: W]),
      .o_sec_in(O_SEC_PAD_IN[B +: W]),
      .o_pri_chg(O_PRI_CHANGE[B +: W]),
      .o_sec_chg(O_SEC_CHANGE[B +: W])
    );
  end

  // Map is loaded from the stored bits on the first edge
  map_load_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_WAIT) |=> (owner == $past(I_OWNER_CFG))
                            && (state == CAP_HELD))
    else $error("ownership map not loaded from configuration");

  // Before the load every pad belongs to the primary core
  erased_map_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_WAIT) |-> (owner == OWN_ERASED))
    else $error("pads not all primary before map load");

  // Once loaded the map never moves again
  map_hold_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_HELD) |=> $stable(owner) && (state == CAP_HELD)
                           && (O_OWNER_MAP == owner))
    else $error("ownership map changed after load");

  // Analog selection always keeps the digital driver off
  analog_drv_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (O_PAD_ANALOG & ~O_PAD_OE_N) == '0)
    else $error("pad driven while analog selected");

  // Primary-owned pads follow primary pull-up one cycle later
  pri_pullup_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_HELD) |=>
      ((O_PAD_PULLUP ^ $past(I_PRI_PULLUP_ENABLE_CTRL))
       & $past(owner)) == '0)
    else $error("primary pull-up not applied to owned pad");

  // Secondary pull-down writes never reach primary-owned pads
  sec_ignored_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_HELD) ##1 $stable(I_PRI_PULLDOWN_ENABLE_CTRL) |=>
      ((O_PAD_PULLDOWN ^ $past(O_PAD_PULLDOWN)) & owner) == '0)
    else $error("non-owner write disturbed a pad");

  // Open-drain pads only ever pull low
  od_low_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (O_PAD_OPEN_DRAIN & ~O_PAD_OE_N & O_PAD_OUT) == '0)
    else $error("open-drain pad driven high");

  // Both cores see the same pad value
  both_in_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_PRI_PAD_IN == O_SEC_PAD_IN)
    else $error("cores disagree on pad input");

  // Input follows the pad one cycle later whatever the owner
  in_free_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_HELD) |=> (O_SEC_PAD_IN == $past(I_PAD_IN)))
    else $error("input path blocked");

  // Primary core sees the pad one cycle later as well
  pri_in_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_HELD) |=> (O_PRI_PAD_IN == $past(I_PAD_IN)))
    else $error("primary input path blocked");

  // Secondary-owned pads follow secondary pull-up one cycle later
  sec_pullup_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_HELD) |=>
      ((O_PAD_PULLUP ^ $past(I_SEC_PULLUP_ENABLE_CTRL))
       & ~$past(owner)) == '0)
    else $error("secondary pull-up not applied to owned pad");

  // Primary change events only on bits the primary enabled
  pri_chg_en_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_HELD) |=>
      (O_PRI_CHANGE & ~$past(I_PRI_CHANGE_ENABLE)) == '0)
    else $error("primary change event on disabled pad");

  // Valid flag and reported map agree with the live map once loaded
  map_report_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_HELD) |-> O_MAP_VALID && (O_OWNER_MAP == owner))
    else $error("map report disagrees with live map");

  // An enabled pad change raises a change event next cycle
  change_evt_a: assert property (
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (state == CAP_HELD) && $past(state == CAP_HELD)
    && (((I_PAD_IN ^ $past(I_PAD_IN)) & I_SEC_CHANGE_ENABLE) != '0)
    |=> (O_SEC_CHANGE != '0))
    else $error("pad change missed by secondary core");

endmodule
`default_nettype wire

/* dcpm_top_bench.sv */
// Self-checking bench for the dual-core pad ownership multiplexer
`timescale 1ns/1ps
`default_nettype none
module dcpm_top_bench
  import dcpm_pkg::*;
;
  localparam int HALF = 25; // Half period of the 20 MHz clock
  localparam int LIMIT = 2000; // Cycles allowed before giving up
  logic clk; // Reference clock
  logic rst_n; // Asynchronous reset, active low
  logic [PIN_CNT-1:0] cfg; // Stored ownership bits
  logic [PIN_CNT-1:0] pad_in; // Pad input levels
  // Core controls: out, drive, analog, pu, pd, od, slew, change enable
  logic [PIN_CNT-1:0] pri [8];
  logic [PIN_CNT-1:0] sec [8];
  logic [PIN_CNT-1:0] o [12]; // Design outputs in a fixed order
  logic vld; // Map loaded flag
  logic [PIN_CNT-1:0] e [12]; // Expected outputs
  logic ev; // Expected map loaded flag
  logic [PIN_CNT-1:0] map; // Model ownership map
  logic [PIN_CNT-1:0] prev; // Model previous pad sample
  logic first; // Next edge is the first after release
  int fails; // Mismatch counter
  int compares; // Comparison counter
  integer seed; // Random seed
  string nm [12] = '{"pad_out", "pad_oe_n", "analog", "pullup",
    "pulldown", "open_drain", "slew", "pri_in", "sec_in", "pri_change",
    "sec_change", "owner_map"};

  dcpm_top dcpm_top_i (
    .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_OWNER_CFG(cfg),
    .I_PAD_IN(pad_in),
    .I_PRI_PORT_OUT(pri[0]), .I_PRI_DRIVE_ENABLE(pri[1]),
    .I_PRI_ANALOG_SELECT_CTRL(pri[2]), .I_PRI_PULLUP_ENABLE_CTRL(pri[3]),
    .I_PRI_PULLDOWN_ENABLE_CTRL(pri[4]), .I_PRI_OPEN_DRAIN_CTRL(pri[5]),
    .I_PRI_SLEW_CTRL(pri[6]), .I_PRI_CHANGE_ENABLE(pri[7]),
    .I_SEC_PORT_OUT(sec[0]), .I_SEC_DRIVE_ENABLE(sec[1]),
    .I_SEC_ANALOG_SELECT_CTRL(sec[2]), .I_SEC_PULLUP_ENABLE_CTRL(sec[3]),
    .I_SEC_PULLDOWN_ENABLE_CTRL(sec[4]), .I_SEC_OPEN_DRAIN_CTRL(sec[5]),
    .I_SEC_SLEW_CTRL(sec[6]), .I_SEC_CHANGE_ENABLE(sec[7]),
    .O_PAD_OUT(o[0]), .O_PAD_OE_N(o[1]), .O_PAD_ANALOG(o[2]),
    .O_PAD_PULLUP(o[3]), .O_PAD_PULLDOWN(o[4]), .O_PAD_OPEN_DRAIN(o[5]),
    .O_PAD_SLEW(o[6]), .O_PRI_PAD_IN(o[7]), .O_SEC_PAD_IN(o[8]),
    .O_PRI_CHANGE(o[9]), .O_SEC_CHANGE(o[10]), .O_OWNER_MAP(o[11]),
    .O_MAP_VALID(vld)
  );

  // Free-running clock
  initial begin
    clk = 1'h0;
    forever #HALF clk = ~clk;
  end

  // Random vector as wide as the pad population
  function automatic logic [PIN_CNT-1:0] rnd();
    logic [95:0] w;
    w = {$random(seed), $random(seed), $random(seed)};
    return w[PIN_CNT-1:0];
  endfunction

  // Per-pad choice of the owner's value
  function automatic logic [PIN_CNT-1:0] pick(
    input logic [PIN_CNT-1:0] own, p, s);
    return (own & p) | (~own & s);
  endfunction

  // Compare one value and count it
  task automatic check(input string what,
                       input logic [PIN_CNT-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // New stimulus on core controls and pads; toggle mode flips every pad and holds the primary pull-down
  task automatic drive(input bit toggle);
    for (int k = 0; k < 8; k++) begin
      // Toggle mode holds the primary pull-down so the hold check fires
      if (!toggle || k != 4) pri[k] = rnd();
      sec[k] = rnd();
    end
    if (toggle) begin
      pad_in = ~pad_in;
      pri[7] = '1; // Sec enable stays random, so refusals show too
    end else begin
      pad_in = rnd();
    end
  endtask

  // Expected outputs after one rising edge, from inputs held since negedge
  task automatic predict();
    logic [PIN_CNT-1:0] s [8];
    logic [PIN_CNT-1:0] chg;
    for (int k = 0; k < 8; k++) s[k] = pick(map, pri[k], sec[k]);
    e[0] = s[0] & ~s[5];
    e[1] = ~(s[1] & ~s[2] & ~(s[5] & s[0]));
    for (int k = 2; k < 7; k++) e[k] = s[k];
    e[7] = pad_in;
    e[8] = pad_in;
    // No change pulse on the first edge: there is no valid prior sample
    chg = first ? '0 : (pad_in ^ prev);
    e[9] = chg & pri[7];
    e[10] = chg & sec[7];
    prev = pad_in;
    if (first) map = cfg;
    first = 1'h0;
    e[11] = map;
    ev = 1'h1;
  endtask

  // One clock: predict at the rising edge, compare and redrive at falling
  task automatic cycle(input bit toggle);
    @(posedge clk);
    predict();
    @(negedge clk);
    for (int k = 0; k < 7; k++) check(nm[k], o[k], e[k]);
    for (int k = 7; k < 9; k++) check(nm[k], o[k], e[k]);
    check(nm[9], o[9], e[9]);
    check(nm[10], o[10], e[10]);
    check(nm[11], o[11], e[11]);
    check("map_valid", PIN_CNT'(vld), PIN_CNT'(ev));
    drive(toggle);
    cfg = rnd(); // Must be ignored once the map is taken
  endtask

  // Reset for six cycles, then run one scenario
  task automatic run(input string name, input logic [PIN_CNT-1:0] c,
                     input int n, input bit toggle);
    @(negedge clk);
    rst_n = 1'h0;
    map = OWN_ERASED;
    prev = '0;
    first = 1'h1;
    repeat (6) begin
      @(negedge clk);
      check("reset_oe_n", o[1], '1);
      check("reset_map", o[11], OWN_ERASED);
      check("reset_pad_out", o[0], '0);
      check("reset_valid", PIN_CNT'(vld), '0);
      drive(toggle);
    end
    cfg = c; // Held steady across the capture edge
    rst_n = 1'h1;
    repeat (n) cycle(toggle);
    $display("test %s done", name);
  endtask

  // Main sequence
  initial begin
    seed = 32'hbb92;
    fails = 0;
    compares = 0;
    rst_n = 1'h0;
    cfg = '1;
    pad_in = '0;
    for (int k = 0; k < 8; k++) begin
      pri[k] = '0;
      sec[k] = '0;
    end
    run("erased", '1, 150, 1'b0);
    run("mixed", rnd(), 200, 1'b0);
    run("secondary", '0, 100, 1'b1);
    run("toggle_mixed", rnd(), 100, 1'b1);
    summarize();
  end

  // Watchdog against a hang
  initial begin
    #(LIMIT * 2 * HALF);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
